// ### verilog/cpu_bus_master.sv
// Purpose: Processor end of the pipelined memory bus, driven by AHB-Lite
// Assumes: Memory answers each bus cycle in one clock
// Notes: Software sets up a transfer, sets go, polls busy
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "cpu_bus_map.svh"

// Overview of operation
// - Drive byte address, burst word adds four
// - Memory ignores insignificant low address bits
// - Write high, read low, fixed in burst
// - Size 00 byte, 01 half, 10 word
// - Size constant across sequential burst
// - Memory provides per-byte write enables
// - Protection: upper privileged, lower data
// - Lock high during atomic swap
// - ISA state low standard, high compact
// - Write data valid only in write cycles
// - Write bus also carries coprocessor data
// - Read bus sampled at cycle end
// - Abort sampled only on N/S cycles
// - Data abort traps; fetch abort marked
// - Narrow reads may return whole word
// - Halfword lane by address bit one
// - Byte lanes by low address bits
// - Word reads use whole bus
// - Narrow writes replicated across lanes
// - Endian input: 0 little, 1 big
// - Cycle type: I, C, N, S codes
// - Address phase one cycle before data
module cpu_bus_master
  import cpu_bus_pkg::*;
#(
  parameter int BURST_W = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic endian_select,
  cpu_bus_if.cpu bus
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    bus_state_e st;
    logic ap_wr;
    logic [31:0] ap_addr;
    logic [31:0] ctl;
    logic [31:0] addr;
    logic [31:0] wval;
    logic [31:0] rval;
    logic [BURST_W-1:0] left;
    logic dabt;
    logic pabt;
    logic [31:0] b_addr;
    logic b_write;
    logic [1:0] b_size;
    logic [1:0] b_prot;
    logic b_lock;
    logic b_isa;
    logic [1:0] b_cyc;
    logic [31:0] b_wdata;
    logic d_act;
    logic d_prot_data;
    logic d_write;
    logic [1:0] d_cyc;
  } state_s;

  state_s s_r, s_nxt;
  logic [31:0] rfield, wbus;
  logic [1:0] req_size;

  function automatic logic [31:0] step(input logic [1:0] sz);
    return (sz == `SIZE_WORD) ? `WORD_STEP : `HALF_STEP;
  endfunction : step

  assign req_size = (s_r.ctl[`CTL_SIZE_LSB +: 2] == `SIZE_RSVD) ?
    `SIZE_WORD : s_r.ctl[`CTL_SIZE_LSB +: 2];

  lane_select i_lane_select (
    .rword(bus.rdata),
    .addr_lo(s_r.b_addr[1:0]),
    .size(s_r.b_size),
    .endian_select(endian_select),
    .wvalue(s_r.wval),
    .rfield(rfield),
    .wbus(wbus)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    if (hready && hsel && htrans[1]) begin
      s_nxt.ap_wr = hwrite;
      s_nxt.ap_addr = haddr;
    end else if (hready) begin
      s_nxt.ap_wr = 1'b0;
    end
    s_nxt.d_act = 1'b0;
    s_nxt.b_cyc = `CYC_INTERNAL;
    s_nxt.b_lock = 1'b0;
    s_nxt.b_wdata = 32'h00000000;
    unique case (s_r.st)
      ST_IDLE: begin
        if (s_r.ctl[`CTL_GO_BIT]) begin
          s_nxt.ctl[`CTL_GO_BIT] = 1'b0;
          s_nxt.dabt = 1'b0;
          s_nxt.pabt = 1'b0;
          s_nxt.st = ST_ADDR;
          s_nxt.b_addr = s_r.addr;
          s_nxt.b_write = s_r.ctl[`CTL_WRITE_BIT];
          s_nxt.b_size = req_size;
          // Privilege high bit, data low bit
          s_nxt.b_prot = {s_r.ctl[`CTL_PRIV_BIT], s_r.ctl[`CTL_DATA_BIT]};
          s_nxt.b_isa = s_r.ctl[`CTL_ISA_BIT];
          s_nxt.left = s_r.ctl[`CTL_BURST_LSB +: BURST_W];
          s_nxt.b_cyc = s_r.ctl[`CTL_COPROC_BIT] ? `CYC_COPROC :
            `CYC_NONSEQ;
          s_nxt.b_lock = s_r.ctl[`CTL_LOCK_BIT];
        end
      end
      ST_ADDR, ST_DATA: begin
        // Data follows address by one cycle
        s_nxt.d_act = 1'b1;
        s_nxt.d_prot_data = s_r.b_prot[`PROT_DATA_BIT];
        s_nxt.d_write = s_r.b_write;
        s_nxt.d_cyc = s_r.b_cyc;
        // Write data for memory and coprocessor
        if (s_r.b_write) begin
          s_nxt.b_wdata = wbus;
        end
        if (s_r.left != '0 && s_r.b_cyc != `CYC_COPROC) begin
          s_nxt.left = s_r.left - 1'b1;
          s_nxt.b_addr = s_r.b_addr + step(s_r.b_size);
          s_nxt.b_cyc = `CYC_SEQ;
          // Direction and size kept in burst
          s_nxt.b_lock = s_r.b_lock;
          s_nxt.st = ST_DATA;
        end else if (s_r.b_lock && !s_r.b_write) begin
          s_nxt.b_write = 1'b1;
          s_nxt.b_cyc = `CYC_NONSEQ;
          s_nxt.b_lock = 1'b1;
          s_nxt.st = ST_DATA;
        end else begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // Software write after the go clear, so a fresh go is kept
    if (s_r.ap_wr) begin
      unique case (s_r.ap_addr[7:0])
        `CTL_OFS: s_nxt.ctl = hwdata;
        `ADDR_OFS: s_nxt.addr = hwdata;
        `WDATA_OFS: s_nxt.wval = hwdata;
        default: ;
      endcase
    end
    // Data sampled at end of its own data cycle
    if (s_r.d_act) begin
      if (!s_r.d_write) begin
        s_nxt.rval = rfield;
      end
      // Abort only on N or S
      if (bus.abort && s_r.d_cyc[1]) begin
        if (s_r.d_prot_data) begin
          s_nxt.dabt = 1'b1;
        end else begin
          s_nxt.pabt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_comb begin
    unique case (s_r.ap_addr[7:0])
      `CTL_OFS: hrdata = s_r.ctl;
      `ADDR_OFS: hrdata = s_r.addr;
      `WDATA_OFS: hrdata = s_r.wval;
      `RDATA_OFS: hrdata = s_r.rval;
      `STAT_OFS: hrdata = {29'h0, s_r.pabt, s_r.dabt,
        (s_r.st != ST_IDLE) || s_r.d_act || s_r.ctl[`CTL_GO_BIT]};
      default: hrdata = 32'h00000000;
    endcase
  end

  assign bus.addr = s_r.b_addr;
  assign bus.write = s_r.b_write;
  assign bus.size = s_r.b_size;
  assign bus.access_protection = s_r.b_prot;
  assign bus.lock = s_r.b_lock;
  assign bus.compact_isa_state = s_r.b_isa;
  assign bus.cycle_type = s_r.b_cyc;
  assign bus.wdata = s_r.b_wdata;
endmodule : cpu_bus_master

// ### verilog/cpu_bus_map.svh
// Purpose: Constants of the pipelined processor memory bus
// Assumes: Included by the modules by bare name
// Notes: Codes and widths only
`ifndef CPU_BUS_MAP_SVH
`define CPU_BUS_MAP_SVH
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define SIZE_RSVD 2'h3
`define CYC_INTERNAL 2'h0
`define CYC_COPROC 2'h1
`define CYC_NONSEQ 2'h2
`define CYC_SEQ 2'h3
`define PROT_PRIV_BIT 1
`define PROT_DATA_BIT 0
`define WORD_STEP 32'h4
`define HALF_STEP 32'h2
`define CTL_OFS 32'h0000_0000
`define ADDR_OFS 32'h0000_0004
`define WDATA_OFS 32'h0000_0008
`define RDATA_OFS 32'h0000_000C
`define STAT_OFS 32'h0000_0010
`define CTL_GO_BIT 0
`define CTL_WRITE_BIT 1
`define CTL_SIZE_LSB 2
`define CTL_PRIV_BIT 4
`define CTL_DATA_BIT 5
`define CTL_LOCK_BIT 6
`define CTL_ISA_BIT 7
`define CTL_BURST_LSB 8
`define CTL_COPROC_BIT 12
`define STAT_BUSY_BIT 0
`define STAT_DABT_BIT 1
`define STAT_PABT_BIT 2
`endif

// ### verilog/cpu_bus_pkg.sv
// Purpose: Types shared by both ends of the processor memory bus
// Assumes: cpu_bus_map.svh defines the codes
// Notes: Types only
package cpu_bus_pkg;
  typedef logic [1:0] size_t;
  typedef logic [1:0] cyc_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} bus_state_e;
endpackage : cpu_bus_pkg

// ### verilog/cpu_bus_if.sv
// Purpose: Carrier joining the processor end and the memory end
// Assumes: One clock, all signals change after rising edges
// Notes: No two-way pins
`timescale 1ns/10ps
interface cpu_bus_if;
  logic [31:0] addr;
  logic write;
  logic [1:0] size;
  logic [1:0] access_protection;
  logic lock;
  logic compact_isa_state;
  logic [1:0] cycle_type;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic abort;
  modport cpu (output addr, write, size, access_protection, lock,
    compact_isa_state, cycle_type, wdata, input rdata, abort);
  modport mem (input addr, write, size, access_protection, lock,
    compact_isa_state, cycle_type, wdata, output rdata, abort);
endinterface : cpu_bus_if

// ### verilog/lane_select.sv
// Purpose: Pick the addressed field of a read word, replicate writes
// Assumes: Combinational, pure lane steering
// Notes: Used by the processor end
`timescale 1ns/10ps
`include "cpu_bus_map.svh"
module lane_select
  import cpu_bus_pkg::*;
(
  input wire logic [31:0] rword,
  input wire logic [1:0] addr_lo,
  input wire logic [1:0] size,
  input wire logic endian_select,
  input wire logic [31:0] wvalue,
  output logic [31:0] rfield,
  output logic [31:0] wbus
);
  logic [1:0] lane;
  always_comb begin
    lane = endian_select ? ~addr_lo : addr_lo;
    rfield = rword;
    wbus = wvalue;
    unique case (size)
      `SIZE_BYTE: begin
        rfield = {24'h000000, rword[8*lane +: 8]};
        wbus = {4{wvalue[7:0]}};
      end
      `SIZE_HALF: begin
        rfield = {16'h0000, rword[16*lane[1] +: 16]};
        wbus = {2{wvalue[15:0]}};
      end
      default: rfield = rword;
    endcase
  end
endmodule : lane_select

// ### verilog/cpu_bus_memory.sv
// Purpose: Memory end with byte write enables and abort window
// Assumes: Zero-wait memory, one bus cycle per clock
// Notes: N or S cycles at addresses at or above abort_base abort
`timescale 1ns/10ps
`include "cpu_bus_map.svh"
module cpu_bus_memory
  import cpu_bus_pkg::*;
#(
  parameter int DEPTH_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] abort_base,
  input wire logic [31:0] coproc_value,
  output logic [31:0] coproc_seen,
  cpu_bus_if.mem bus
);
  typedef struct packed {
    logic act;
    logic cp;
    logic wr;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] rdata;
    logic abort;
    logic [31:0] cp_seen;
  } mem_s;
  mem_s s_r, s_nxt;
  logic [31:0] mem [0:(1<<DEPTH_W)-1];
  logic [3:0] be;
  logic [DEPTH_W-1:0] idx;

  function automatic logic [3:0] byte_en(input logic [1:0] sz,
                                         input logic [1:0] a);
    unique case (sz)
      `SIZE_BYTE: return 4'h1 << a;
      `SIZE_HALF: return a[1] ? 4'hC : 4'h3;
      default: return 4'hF;
    endcase
  endfunction : byte_en

  assign idx = s_r.addr[DEPTH_W+1:2];
  assign be = byte_en(s_r.size, s_r.addr[1:0]);

  always_comb begin
    s_nxt = s_r;
    // Commit only on N or S; pipelined to the next cycle
    s_nxt.act = bus.cycle_type[1];
    s_nxt.cp = (bus.cycle_type == `CYC_COPROC);
    s_nxt.wr = bus.write;
    s_nxt.size = bus.size;
    s_nxt.addr = bus.addr;
    s_nxt.abort = bus.cycle_type[1] && (bus.addr >= abort_base);
    // Whole word returned for any size
    s_nxt.rdata = mem[bus.addr[DEPTH_W+1:2]];
    if (bus.cycle_type == `CYC_COPROC) begin
      s_nxt.rdata = coproc_value;
    end
    if (s_r.cp && s_r.wr) begin
      s_nxt.cp_seen = bus.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Write data captured at cycle end
  always_ff @(posedge hclk) begin
    if (s_r.act && s_r.wr && !s_r.abort) begin
      for (int i = 0; i < 4; i++) begin
        if (be[i]) begin
          mem[idx][8*i +: 8] <= bus.wdata[8*i +: 8];
        end
      end
    end
  end

  assign bus.rdata = s_r.rdata;
  assign bus.abort = s_r.act && s_r.abort;
  assign coproc_seen = s_r.cp_seen;
endmodule : cpu_bus_memory

// ### bench/cpu_bus_lanes_checker.sv
// Purpose: Assertions on the bus between processor and memory ends
// Assumes: One clock, async active-low reset
// Notes: Sees carrier signals only
`timescale 1ns/10ps
module cpu_bus_lanes_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] addr,
  input wire logic write,
  input wire logic [1:0] size,
  input wire logic [1:0] access_protection,
  input wire logic lock,
  input wire logic [1:0] cycle_type,
  input wire logic [31:0] wdata,
  input wire logic abort
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic wr_ns;
  assign wr_ns = write && cycle_type[1];
  ////////////////////////////////////////////////////////////////////////////
  chk_size_legal: assert property (size != 2'h3)
    else $error("reserved size code driven");
  chk_burst_step: assert property (cycle_type == 2'h3 |->
    addr == $past(addr) + ((size == 2'h2) ? 32'h4 : 32'h2))
    else $error("burst address step wrong");
  chk_burst_dir: assert property (cycle_type == 2'h3 |->
    $stable(write) && $stable(access_protection))
    else $error("direction changed in burst");
  chk_burst_size: assert property (cycle_type == 2'h3 |->
    $stable(size))
    else $error("size changed in burst");
  chk_wdata_quiet: assert property (!$past(write) |-> wdata == 32'h0)
    else $error("write data outside write cycle");
  chk_byte_copies: assert property ($past(wr_ns) &&
    $past(size) == 2'h0 |-> wdata == {4{wdata[7:0]}})
    else $error("byte write not replicated");
  chk_half_copies: assert property ($past(wr_ns) &&
    $past(size) == 2'h1 |-> wdata == {2{wdata[15:0]}})
    else $error("halfword write not replicated");
  chk_lock_pair: assert property ($rose(lock) |->
    (!write && cycle_type == 2'h2) ##[1:4]
    (lock && write && cycle_type == 2'h2))
    else $error("locked swap pair malformed");
  chk_abort_window: assert property (abort |-> $past(cycle_type[1]))
    else $error("abort outside memory cycle");
  cov_burst: cover property (cycle_type == 2'h3);
  cov_lock: cover property ($rose(lock));
  cov_abort: cover property (abort);
endmodule : cpu_bus_lanes_checker

// ### bench/cpu_bus_address_data_lanes_test.sv
// Purpose: Drives both bus ends through the register port
// Assumes: Zero-wait register slave, memory answers each cycle
// Notes: Memory window at 0x80 and above aborts
`timescale 1ns/10ps
`include "cpu_bus_map.svh"
module cpu_bus_address_data_lanes_test;
  import cpu_bus_pkg::*;
  localparam logic [31:0] W = 32'hBEEF_5A44;
  logic hclk, hresetn, hsel, hwrite, endian_select, hreadyout, hresp;
  logic [1:0] htrans, last_prot, last_size;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, abort_base, coproc_value, coproc_seen;
  logic last_isa;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_seen = 0;
  cpu_bus_if bus();
  cpu_bus_master i_cpu_bus_master (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .endian_select(endian_select),
    .bus(bus.cpu));
  cpu_bus_memory i_cpu_bus_memory (.hclk(hclk), .hresetn(hresetn),
    .abort_base(abort_base), .coproc_value(coproc_value),
    .coproc_seen(coproc_seen), .bus(bus.mem));
  cpu_bus_lanes_checker i_cpu_bus_lanes_checker (.hclk(hclk),
    .hresetn(hresetn), .addr(bus.addr), .write(bus.write), .size(bus.size),
    .access_protection(bus.access_protection), .lock(bus.lock),
    .cycle_type(bus.cycle_type), .wdata(bus.wdata), .abort(bus.abort));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (bus.cycle_type == 2'h2) begin
      n_seen <= n_seen + 1;
      last_prot <= bus.access_protection;
      last_size <= bus.size;
      last_isa <= bus.compact_isa_state;
    end
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [31:0] a, wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask : rd
  // Start a transfer, wait for idle, check its address-class codes
  task automatic run(input logic [31:0] ctl);
    logic [31:0] s;
    logic [1:0] exp_size;
    int n0;
    n0 = n_seen;
    wr(`CTL_OFS, ctl);
    s = 32'h1;
    while (s[0] !== 1'b0) rd(`STAT_OFS, s);
    if (!ctl[12]) begin
      exp_size = (ctl[3:2] == 2'h3) ? 2'h2 : ctl[3:2];
      check("ncycle", {31'h0, n_seen != n0}, 32'h1);
      check("size", {30'h0, last_size}, {30'h0, exp_size});
      check("prot", {30'h0, last_prot}, {30'h0, ctl[4], ctl[5]});
      check("isa", {31'h0, last_isa}, {31'h0, ctl[7]});
    end
  endtask : run
  task automatic report_and_stop;
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    int k;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    endian_select = 1'b0;
    abort_base = 32'h80;
    coproc_value = 32'hC0DE_5A17;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`STAT_OFS, v);
    check("stat_reset", v, 32'h0);
    rd(32'h14, v);
    check("unmapped", v, 32'h0);
    // Word store, then narrow stores replicated into lanes
    wr(`WDATA_OFS, 32'h1122_3344);
    wr(`ADDR_OFS, 32'h20);
    run(32'h3B);
    wr(`WDATA_OFS, 32'h5A);
    wr(`ADDR_OFS, 32'h21);
    run(32'h23);
    wr(`WDATA_OFS, 32'hBEEF);
    wr(`ADDR_OFS, 32'h22);
    run(32'h27);
    // Lane extraction in both endian modes
    for (int e = 0; e < 2; e++) begin
      endian_select <= e[0];
      for (int i = 0; i < 4; i++) begin
        k = e ? 3 - i : i;
        wr(`ADDR_OFS, 32'h20 + 32'(i));
        run(32'h21);
        rd(`RDATA_OFS, v);
        check("byte", v, {24'h0, W[8*k +: 8]});
      end
      for (int i = 0; i < 2; i++) begin
        k = e ? 1 - i : i;
        wr(`ADDR_OFS, 32'h20 + 32'(2 * i));
        run(32'h25);
        rd(`RDATA_OFS, v);
        check("half", v, {16'h0, W[16*k +: 16]});
      end
      wr(`ADDR_OFS, 32'h23);
      run(32'hA9);
      rd(`RDATA_OFS, v);
      check("word", v, W);
    end
    endian_select <= 1'b0;
    // Bursts of four writes and three reads
    wr(`WDATA_OFS, 32'h0F0F_A5A5);
    wr(`ADDR_OFS, 32'h40);
    run(32'h33B);
    wr(`ADDR_OFS, 32'h4C);
    run(32'h29);
    rd(`RDATA_OFS, v);
    check("burst_wr", v, 32'h0F0F_A5A5);
    wr(`ADDR_OFS, 32'h40);
    run(32'h229);
    rd(`RDATA_OFS, v);
    check("burst_rd", v, 32'h0F0F_A5A5);
    // Aborts on data and opcode, both at the window base 0x80
    wr(`ADDR_OFS, 32'h80);
    run(32'h29);
    rd(`STAT_OFS, v);
    check("data_abort", v & 32'h6, 32'h2);
    run(32'h19);
    rd(`STAT_OFS, v);
    check("fetch_abort", v & 32'h6, 32'h4);
    // Coprocessor cycles ignore the abort window
    wr(`WDATA_OFS, 32'h1357_9BDF);
    run(32'h102B);
    check("cp_out", coproc_seen, 32'h1357_9BDF);
    run(32'h1029);
    rd(`RDATA_OFS, v);
    check("cp_in", v, 32'hC0DE_5A17);
    rd(`STAT_OFS, v);
    check("cp_noabort", v & 32'h6, 32'h0);
    // Atomic swap, then reserved size read
    wr(`ADDR_OFS, 32'h20);
    wr(`WDATA_OFS, 32'h77);
    run(32'h69);
    rd(`RDATA_OFS, v);
    check("swap_old", v, W);
    run(32'h2D);
    rd(`RDATA_OFS, v);
    check("swap_new", v, 32'h77);
    report_and_stop();
  end
endmodule : cpu_bus_address_data_lanes_test
